/* File: hdl/pfm_pin_mux.sv */
// How it works
// - Each pin 0-16 drives only the function its field selects; gpio_in reads it in any non-analog function.
// - Analog converter inputs stay wired to the pad whatever is selected.
// - Selecting the analog function disables the pad's digital section.
// - Port direction bit acts only in port function; else function decides.
// - Unrouted enabled peripherals see an idle constant; activity undefined.
// - Two 32-bit read/write select registers, consecutive words, reset zero.
// - Low register holds pin k code in bits 2k+1:2k; 00 is port.
// - Pins 0-6 alternate functions: uart0, i2c0, spi0, timer3 matches.
// - Pins 7-10: spi0 select, uart1, pwm outputs, rts, capture, analog.
// - Pins 11-15: uart1 modem lines, timer1, analog, irqs, ssp clock.
// - High register holds pin 16 code in bits 1:0; 00 is port.
// - Debug select high at reset puts pins 27-31 into debug port.
// - Reset low returns all pins and peripherals to default state.
// - Pin 14 low just after reset release requests the programming command handler.
// - Pin 31 in port function is an output only, never an input.
// - I2C0 pins drive open-drain for every function, port included.
// - I2C1 pins drive open-drain only in their i2c1 function; none here, pins 17 and 18 stay push-pull.
// - Code 00 primary function; 01, 10, 11 first to third alternates.
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
module pfm_pin_mux
  import pfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe,
  output logic [31:0] pad_dig_en,
  input wire logic debug_port_select,
  input wire logic [31:0] gpio_out,
  input wire logic [31:0] port_direction_bits,
  output logic [31:0] gpio_in,
  input wire pfm_periph_out_t periph_out,
  output pfm_periph_in_t periph_in,
  output logic [2:0] adc_reading_valid,
  output pfm_debug_in_t debug_in,
  input wire logic debug_data_out,
  input wire logic debug_data_out_oe,
  output logic debug_mode,
  output logic isp_request
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Pins above 16 have no selectable function here and stay in port mode
  function automatic logic [1:0] field_code(input logic [31:0] low_v,
                                            input logic [31:0] high_v,
                                            input int p);
    logic [1:0] c;
    c = PFM_CODE_PRIMARY;
    if (p < PFM_LOW_PINS) begin
      c = low_v[p*PFM_FIELD_W +: PFM_FIELD_W];
    end else if (p == PFM_PIN_HIGH_FIELD) begin
      c = high_v[PFM_FIELD_W-1:0];
    end
    return c;
  endfunction : field_code

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [31:0] sel_low_q, sel_low_d;
  logic [31:0] sel_high_q, sel_high_d;
  logic [31:0] rdat_q, rdat_d;
  logic ack_q, ack_d;
  logic bus_req;

  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    ack_d = bus_req;
    sel_low_d = sel_low_q;
    sel_high_d = sel_high_q;
    rdat_d = rdat_q;
    if (bus_req) begin
      case (wb_adr_i)
        PFM_SEL_LOW_ADDR: begin
          rdat_d = sel_low_q;
          if (wb_we_i) begin
            sel_low_d = merge_bytes(sel_low_q, wb_dat_i, wb_sel_i);
          end
        end
        PFM_SEL_HIGH_ADDR: begin
          rdat_d = sel_high_q;
          if (wb_we_i) begin
            sel_high_d = merge_bytes(sel_high_q, wb_dat_i, wb_sel_i);
          end
        end
        default: begin
          rdat_d = PFM_READ_UNMAPPED;
        end
      endcase
    end
  end

  // Reset brings every pin back to port function
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_low_q <= PFM_SEL_RESET;
      sel_high_q <= PFM_SEL_RESET;
      rdat_q <= PFM_READ_UNMAPPED;
      ack_q <= 1'b0;
    end else begin
      sel_low_q <= sel_low_d;
      sel_high_q <= sel_high_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [31:0] pin_meta_q, pin_s_q;
  logic dsel_meta_q, dsel_s_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= 32'h00000000;
      pin_s_q <= 32'h00000000;
      dsel_meta_q <= 1'b0;
      dsel_s_q <= 1'b0;
    end else begin
      pin_meta_q <= pad_in;
      pin_s_q <= pin_meta_q;
      dsel_meta_q <= debug_port_select;
      dsel_s_q <= dsel_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------------
  // The synchronisers need two edges before they show the true pin level,
  // so the straps are sampled on the third edge after release.
  pfm_strap_state_t strap_q, strap_d;
  logic debug_mode_q, debug_mode_d;
  logic isp_q, isp_d;

  always_comb begin
    strap_d = strap_q;
    debug_mode_d = debug_mode_q;
    isp_d = isp_q;
    case (strap_q)
      PFM_ST_SYNC1: strap_d = PFM_ST_SYNC2;
      PFM_ST_SYNC2: strap_d = PFM_ST_SAMPLE;
      PFM_ST_SAMPLE: begin
        strap_d = PFM_ST_DONE;
        debug_mode_d = dsel_s_q;
        isp_d = ~pin_s_q[PFM_PIN_ISP];
      end
      PFM_ST_DONE: strap_d = PFM_ST_DONE;
      default: strap_d = PFM_ST_SYNC1;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      strap_q <= PFM_ST_SYNC1;
      debug_mode_q <= 1'b0;
      isp_q <= 1'b0;
    end else begin
      strap_q <= strap_d;
      debug_mode_q <= debug_mode_d;
      isp_q <= isp_d;
    end
  end

  assign debug_mode = debug_mode_q;
  assign isp_request = isp_q;

  // ----------------------------------------------------------------------
  // Pin multiplexer
  // ----------------------------------------------------------------------
  logic [1:0] code [PFM_NUM_PINS];
  logic [31:0] pad_out_q, pad_out_d;
  logic [31:0] pad_oe_q, pad_oe_d;
  logic [31:0] dig_en_q, dig_en_d;
  logic [31:0] gpio_in_q, gpio_in_d;
  logic [2:0] adc_valid_q, adc_valid_d;
  pfm_periph_in_t pin_q, pin_d;
  pfm_debug_in_t dbg_q, dbg_d;
  logic drv, drv_oe;

  always_comb begin
    pad_out_d = 32'h00000000;
    pad_oe_d = 32'h00000000;
    dig_en_d = 32'hFFFFFFFF;
    drv = 1'b0;
    drv_oe = 1'b0;
    for (int p = 0; p < PFM_NUM_PINS; p++) begin
      code[p] = field_code(sel_low_q, sel_high_q, p);
      drv = 1'b0;
      drv_oe = 1'b0;
      if (code[p] == PFM_CODE_PRIMARY) begin
        drv = gpio_out[p];
        drv_oe = port_direction_bits[p];
        if (p == PFM_PIN_OUT_ONLY) begin
          drv_oe = 1'b1;
        end
      end else begin
        // Inputs and reserved codes leave the driver off
        case (p)
          0: begin
            drv = (code[p] == PFM_CODE_ALT1) ? periph_out.uart0_transmit
                                             : periph_out.timer3_match_1;
            drv_oe = (code[p] != PFM_CODE_ALT3);
          end
          1: begin
            drv = periph_out.timer3_match_2;
            drv_oe = (code[p] == PFM_CODE_ALT2);
          end
          2: begin
            drv = periph_out.i2c0_clock_out;
            drv_oe = (code[p] == PFM_CODE_ALT1) & periph_out.i2c0_clock_oe;
          end
          3: begin
            drv = periph_out.i2c0_data_out;
            drv_oe = (code[p] == PFM_CODE_ALT1) & periph_out.i2c0_data_oe;
          end
          4: begin
            drv = periph_out.spi0_clock_out;
            drv_oe = (code[p] == PFM_CODE_ALT1) & periph_out.spi0_clock_oe;
          end
          5: begin
            drv = periph_out.spi0_master_in_out;
            drv_oe = (code[p] == PFM_CODE_ALT1) &
                     periph_out.spi0_master_in_oe;
          end
          6: begin
            drv = periph_out.spi0_master_out_out;
            drv_oe = (code[p] == PFM_CODE_ALT1) &
                     periph_out.spi0_master_out_oe;
          end
          7: begin
            drv = periph_out.pwm_output_0;
            drv_oe = (code[p] == PFM_CODE_ALT2);
          end
          8: begin
            drv = (code[p] == PFM_CODE_ALT1) ? periph_out.uart1_transmit
                                             : periph_out.pwm_output_1;
            drv_oe = (code[p] != PFM_CODE_ALT3);
          end
          9: begin
            drv = periph_out.pwm_output_2;
            drv_oe = (code[p] == PFM_CODE_ALT2);
          end
          10: begin
            drv = periph_out.uart1_request_to_send;
            drv_oe = (code[p] == PFM_CODE_ALT1);
          end
          12: begin
            drv = periph_out.timer1_match_0;
            drv_oe = (code[p] == PFM_CODE_ALT2);
          end
          13: begin
            drv = (code[p] == PFM_CODE_ALT2) ? periph_out.timer1_match_1
                  : periph_out.uart1_terminal_ready;
            drv_oe = (code[p] != PFM_CODE_ALT1);
          end
          14: begin
            drv = periph_out.ssp_clock_out;
            drv_oe = (code[p] == PFM_CODE_ALT2) &
                     periph_out.ssp_clock_oe;
          end
          default: begin
            drv = 1'b0;
            drv_oe = 1'b0;
          end
        endcase
        // Analog selection cuts the digital pad so readings are clean
        if ((p >= 10) && (p <= 12) && (code[p] == PFM_CODE_ALT3)) begin
          dig_en_d[p] = 1'b0;
          drv_oe = 1'b0;
        end
      end
      // Debug port overrides the field on pins 27-31
      if (debug_mode_q && (p >= PFM_PIN_DBG_RESET)) begin
        drv = debug_data_out;
        drv_oe = (p == PFM_PIN_DBG_DATA_OUT) & debug_data_out_oe;
      end
      // I2C0 pads pull low only, whatever function is chosen
      if ((p == PFM_PIN_I2C0_CLOCK) || (p == PFM_PIN_I2C0_DATA)) begin
        drv_oe = drv_oe & ~drv;
        drv = 1'b0;
      end
      // I2C1 is not selectable here, so pins 17 and 18 stay push-pull
      pad_out_d[p] = drv;
      pad_oe_d[p] = drv_oe;
    end
  end

  // Input routing: unrouted inputs see a constant idle level
  always_comb begin
    gpio_in_d = pin_s_q & dig_en_d;
    gpio_in_d[PFM_PIN_OUT_ONLY] = 1'b0;
    pin_d = '0;
    pin_d.uart0_receive = (code[1] == PFM_CODE_ALT1) & pin_s_q[1];
    pin_d.i2c0_clock = (code[2] == PFM_CODE_ALT1) & pin_s_q[2];
    pin_d.i2c0_data = (code[3] == PFM_CODE_ALT1) & pin_s_q[3];
    pin_d.spi0_clock = (code[4] == PFM_CODE_ALT1) & pin_s_q[4];
    pin_d.spi0_master_in = (code[5] == PFM_CODE_ALT1) & pin_s_q[5];
    pin_d.spi0_master_out = (code[6] == PFM_CODE_ALT1) & pin_s_q[6];
    pin_d.spi0_slave_select = (code[7] == PFM_CODE_ALT1) & pin_s_q[7];
    pin_d.uart1_receive = (code[9] == PFM_CODE_ALT1) & pin_s_q[9];
    pin_d.timer1_capture_0 = (code[10] == PFM_CODE_ALT2) & pin_s_q[10];
    pin_d.uart1_clear_to_send = (code[11] == PFM_CODE_ALT1) & pin_s_q[11];
    pin_d.timer1_capture_1 = (code[11] == PFM_CODE_ALT2) & pin_s_q[11];
    pin_d.uart1_data_set_ready = (code[12] == PFM_CODE_ALT1) & pin_s_q[12];
    pin_d.external_irq_1 = (code[14] == PFM_CODE_ALT1) & pin_s_q[14];
    pin_d.ssp_clock = (code[14] == PFM_CODE_ALT2) & pin_s_q[14];
    pin_d.uart1_carrier_detect = (code[14] == PFM_CODE_ALT3) & pin_s_q[14];
    pin_d.external_irq_2 = (code[15] == PFM_CODE_ALT1) & pin_s_q[15];
    pin_d.uart1_ring_indicator =
      (code[15] == PFM_CODE_ALT3) & pin_s_q[15];
    // Converter path itself is analog and never gated; only validity is
    adc_valid_d = {code[12] == PFM_CODE_ALT3, code[11] == PFM_CODE_ALT3,
                   code[10] == PFM_CODE_ALT3};
    // Test clock is sampled, hence the one-sixth limit on its rate
    dbg_d.test_reset = debug_mode_q & pin_s_q[PFM_PIN_DBG_RESET];
    dbg_d.test_mode = debug_mode_q & pin_s_q[PFM_PIN_DBG_MODE];
    dbg_d.test_clock = debug_mode_q & pin_s_q[PFM_PIN_DBG_CLOCK];
    dbg_d.test_data_in = debug_mode_q & pin_s_q[PFM_PIN_DBG_DATA_IN];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pad_out_q <= 32'h00000000;
      pad_oe_q <= 32'h00000000;
      dig_en_q <= 32'hFFFFFFFF;
      gpio_in_q <= 32'h00000000;
      adc_valid_q <= 3'h0;
      pin_q <= '0;
      dbg_q <= '0;
    end else begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
      dig_en_q <= dig_en_d;
      gpio_in_q <= gpio_in_d;
      adc_valid_q <= adc_valid_d;
      pin_q <= pin_d;
      dbg_q <= dbg_d;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign pad_dig_en = dig_en_q;
  assign gpio_in = gpio_in_q;
  assign adc_reading_valid = adc_valid_q;
  assign periph_in = pin_q;
  assign debug_in = dbg_q;

endmodule : pfm_pin_mux

/* File: shared/pfm_pkg.sv */
package pfm_pkg;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] PFM_SEL_LOW_ADDR = 32'hE002C000;
  localparam logic [31:0] PFM_SEL_HIGH_ADDR = 32'hE002C004;
  localparam logic [31:0] PFM_SEL_RESET = 32'h00000000;
  localparam logic [31:0] PFM_READ_UNMAPPED = 32'h00000000;

  // ----------------------------------------------------------------------
  // Select field layout and codes
  // ----------------------------------------------------------------------
  localparam int PFM_FIELD_W = 2;
  localparam int PFM_NUM_PINS = 32;
  localparam int PFM_LOW_PINS = 16;
  localparam logic [1:0] PFM_CODE_PRIMARY = 2'h0;
  localparam logic [1:0] PFM_CODE_ALT1 = 2'h1;
  localparam logic [1:0] PFM_CODE_ALT2 = 2'h2;
  localparam logic [1:0] PFM_CODE_ALT3 = 2'h3;

  // ----------------------------------------------------------------------
  // Pins with special pad behaviour
  // ----------------------------------------------------------------------
  localparam int PFM_PIN_HIGH_FIELD = 16;
  localparam int PFM_PIN_ISP = 14;
  localparam int PFM_PIN_OUT_ONLY = 31;
  localparam int PFM_PIN_I2C0_CLOCK = 2;
  localparam int PFM_PIN_I2C0_DATA = 3;
  localparam int PFM_PIN_DBG_RESET = 27;
  localparam int PFM_PIN_DBG_MODE = 28;
  localparam int PFM_PIN_DBG_CLOCK = 29;
  localparam int PFM_PIN_DBG_DATA_IN = 30;
  localparam int PFM_PIN_DBG_DATA_OUT = 31;

  // ----------------------------------------------------------------------
  // Strap capture sequence, Gray coded
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PFM_ST_SYNC1 = 2'h0,
    PFM_ST_SYNC2 = 2'h1,
    PFM_ST_SAMPLE = 2'h3,
    PFM_ST_DONE = 2'h2
  } pfm_strap_state_t;

  // ----------------------------------------------------------------------
  // Peripheral side carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic uart0_transmit;
    logic uart1_transmit;
    logic uart1_request_to_send;
    logic uart1_terminal_ready;
    logic i2c0_clock_out;
    logic i2c0_clock_oe;
    logic i2c0_data_out;
    logic i2c0_data_oe;
    logic spi0_clock_out;
    logic spi0_clock_oe;
    logic spi0_master_in_out;
    logic spi0_master_in_oe;
    logic spi0_master_out_out;
    logic spi0_master_out_oe;
    logic pwm_output_0;
    logic pwm_output_1;
    logic pwm_output_2;
    logic timer3_match_1;
    logic timer3_match_2;
    logic timer1_match_0;
    logic timer1_match_1;
    logic ssp_clock_out;
    logic ssp_clock_oe;
  } pfm_periph_out_t;

  typedef struct packed {
    logic uart0_receive;
    logic uart1_receive;
    logic uart1_clear_to_send;
    logic uart1_data_set_ready;
    logic uart1_carrier_detect;
    logic uart1_ring_indicator;
    logic i2c0_clock;
    logic i2c0_data;
    logic spi0_clock;
    logic spi0_master_in;
    logic spi0_master_out;
    logic spi0_slave_select;
    logic timer1_capture_0;
    logic timer1_capture_1;
    logic external_irq_1;
    logic external_irq_2;
    logic ssp_clock;
  } pfm_periph_in_t;

  typedef struct packed {
    logic test_reset;
    logic test_mode;
    logic test_clock;
    logic test_data_in;
  } pfm_debug_in_t;

endpackage : pfm_pkg

/* File: test/pfm_pin_mux_asserts.sv */
`timescale 1ns/100ps
module pfm_pin_mux_asserts
  import pfm_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] pad_dig_en,
  input wire logic [31:0] gpio_in,
  input wire logic [2:0] adc_reading_valid,
  input wire pfm_debug_in_t debug_in,
  input wire logic debug_data_out,
  input wire logic debug_data_out_oe,
  input wire logic debug_mode,
  input wire logic isp_request
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------------
  // Edges since reset release, saturating
  // ------------------------------------------------------------------
  logic [2:0] age_q;
  logic [2:0] age_d;
  always_comb begin
    age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      age_q <= 3'h0;
    end else begin
      age_q <= age_d;
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not acknowledged");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_i2c_od;
    pad_out[3:2] == 2'h0;
  endproperty
  a_i2c_od: assert property (p_i2c_od)
    else $error("i2c0 pad driven high");
  property p_pin31_in;
    gpio_in[31] == 1'b0;
  endproperty
  a_pin31_in: assert property (p_pin31_in)
    else $error("pin 31 read as input");
  property p_adc_pad;
    adc_reading_valid == ~{pad_dig_en[12], pad_dig_en[11], pad_dig_en[10]};
  endproperty
  a_adc_pad: assert property (p_adc_pad)
    else $error("analog valid and digital enable disagree");
  property p_adc_undriven;
    !pad_dig_en[10] |-> !pad_oe[10];
  endproperty
  a_adc_undriven: assert property (p_adc_undriven)
    else $error("analog pad driven");
  property p_dbg_drive;
    debug_mode && $past(debug_mode) |-> pad_oe[31] == $past(debug_data_out_oe)
      && (!pad_oe[31] || pad_out[31] == $past(debug_data_out));
  endproperty
  a_dbg_drive: assert property (p_dbg_drive)
    else $error("debug data out not on pin 31");
  property p_dbg_idle;
    !debug_mode && !$past(debug_mode) |-> debug_in == 4'h0;
  endproperty
  a_dbg_idle: assert property (p_dbg_idle)
    else $error("debug inputs active outside debug mode");
  property p_strap_hold;
    age_q >= 3'h4 |-> $stable(debug_mode) && $stable(isp_request);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap result changed after capture");
  c_bus: cover property (wb_ack_o);
  c_dbg: cover property (debug_mode);
  c_isp: cover property (isp_request);
  c_adc: cover property (adc_reading_valid != 3'h0);
endmodule : pfm_pin_mux_asserts

bind pfm_pin_mux pfm_pin_mux_asserts pfm_pin_mux_asserts_i (
  .core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pad_out, .pad_oe,
  .pad_dig_en, .gpio_in, .adc_reading_valid, .debug_in, .debug_data_out,
  .debug_data_out_oe, .debug_mode, .isp_request
);

/* File: test/pfm_board.sv */
`timescale 1ns/100ps
module pfm_board (
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] ext_level,
  output logic [31:0] pad_in
);
  // ------------------------------------------------------------------
  // Pad levels
  // ------------------------------------------------------------------
  // Board parts hold every released pad at ext_level, so no pad floats
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
    // Wired-and with the pull-up: a low from either side wins
    pad_in[3:2] = ext_level[3:2] & ~pad_oe[3:2];
  end
endmodule : pfm_board

/* File: test/pfm_pin_mux_bench.sv */
`timescale 1ns/100ps
module pfm_pin_mux_bench
  import pfm_pkg::*;
;
  logic core_clk = 1'b0, resetn = 1'b0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic debug_port_select = 1'b0, debug_data_out = 1'b0;
  logic debug_data_out_oe = 1'b0, debug_mode, isp_request;
  logic [3:0] wb_sel_i = 4'h0;
  logic [2:0] adc_reading_valid;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, gpio_out = 32'h0;
  logic [31:0] port_direction_bits = 32'h0, ext = 32'hFFFFFFFF;
  logic [31:0] wb_dat_o, pad_in, pad_out, pad_oe, pad_dig_en, gpio_in;
  pfm_periph_out_t periph_out = '0;
  pfm_periph_in_t periph_in;
  pfm_debug_in_t debug_in;
  logic [31:0] rd_q[$];
  int err_total = 0, checks_done = 0, cycles = 0;
  int tp[24] = '{0,0,0,0,1,2,4,5,6,7,8,8,9,10,10,12,13,13,13,14,15,16,16,17};
  int tc[24] = '{0,1,2,3,2,1,1,1,1,2,1,2,2,1,3,2,1,2,3,2,2,0,1,0};

  pfm_pin_mux pfm_pin_mux_i (
    .core_clk, .resetn, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pad_in, .pad_out, .pad_oe,
    .pad_dig_en, .debug_port_select, .gpio_out, .port_direction_bits,
    .gpio_in, .periph_out, .periph_in, .adc_reading_valid, .debug_in,
    .debug_data_out, .debug_data_out_oe, .debug_mode, .isp_request
  );
  pfm_board pfm_board_i (.pad_out, .pad_oe, .ext_level(ext), .pad_in);

  always #10 core_clk = ~core_clk;

  // ------------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------------
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : check_val

  task automatic final_report();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  // Read results are matched against the oldest noted expectation
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      check_val(wb_dat_o, rd_q.pop_front());
    end
  end

  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  // For a read, d is the expected data
  task automatic wb(input logic [31:0] a, input logic [31:0] d,
                    input logic w, input logic [3:0] s);
    if (!w) begin
      rd_q.push_back(d);
    end
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge core_clk);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task automatic set_pin(input int p, input logic [1:0] c);
    logic [31:0] v;
    v = 32'h0;
    v[(p % 16) * 2 +: 2] = c;
    wb(p < 16 ? PFM_SEL_LOW_ADDR : PFM_SEL_HIGH_ADDR, v, 1'b1, 4'hF);
    // Covers the two synchroniser stages and the output flop
    repeat (4) @(posedge core_clk);
  endtask : set_pin

  task automatic do_reset(input logic [31:0] lv, input logic dsel);
    resetn <= 1'b0;
    ext <= lv;
    debug_port_select <= dsel;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : do_reset

  function automatic logic [1:0] exp_pad(input int p, input logic [1:0] c);
    pfm_periph_out_t o;
    o = periph_out;
    case ({p[4:0], c})
      {5'd0, 2'h0}, {5'd16, 2'h0}, {5'd17, 2'h0}:
        return {port_direction_bits[p], gpio_out[p]};
      {5'd0, 2'h1}: return {1'b1, o.uart0_transmit};
      {5'd0, 2'h2}: return {1'b1, o.timer3_match_1};
      {5'd1, 2'h2}: return {1'b1, o.timer3_match_2};
      {5'd2, 2'h1}: return {o.i2c0_clock_oe & ~o.i2c0_clock_out, 1'b0};
      {5'd4, 2'h1}: return {o.spi0_clock_oe, o.spi0_clock_out};
      {5'd5, 2'h1}: return {o.spi0_master_in_oe, o.spi0_master_in_out};
      {5'd6, 2'h1}: return {o.spi0_master_out_oe, o.spi0_master_out_out};
      {5'd7, 2'h2}: return {1'b1, o.pwm_output_0};
      {5'd8, 2'h1}: return {1'b1, o.uart1_transmit};
      {5'd8, 2'h2}: return {1'b1, o.pwm_output_1};
      {5'd9, 2'h2}: return {1'b1, o.pwm_output_2};
      {5'd10, 2'h1}: return {1'b1, o.uart1_request_to_send};
      {5'd12, 2'h2}: return {1'b1, o.timer1_match_0};
      {5'd13, 2'h2}: return {1'b1, o.timer1_match_1};
      {5'd13, 2'h3}: return {1'b1, o.uart1_terminal_ready};
      {5'd14, 2'h2}: return {o.ssp_clock_oe, o.ssp_clock_out};
      // Reserved and analog codes leave the pad undriven
      default: return 2'h0;
    endcase
  endfunction : exp_pad

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [1:0] e;
    logic [31:0] r1, r2, lv;
    r1 = $urandom(32'h310C);
    do_reset(32'hFFFFFFFF, 1'b0);
    check_val(32'({debug_mode, isp_request}), 32'h0);
    check_val(pad_dig_en, 32'hFFFFFFFF);
    wb(PFM_SEL_LOW_ADDR, PFM_SEL_RESET, 1'b0, 4'hF);
    wb(PFM_SEL_HIGH_ADDR, PFM_SEL_RESET, 1'b0, 4'hF);
    wb(32'hE002C008, PFM_READ_UNMAPPED, 1'b0, 4'hF);
    r1 = $urandom;
    r2 = $urandom;
    wb(PFM_SEL_LOW_ADDR, r1, 1'b1, 4'hF);
    wb(PFM_SEL_LOW_ADDR, r2, 1'b1, 4'h5);
    wb(32'hE002C008, r2, 1'b1, 4'hF);
    wb(PFM_SEL_LOW_ADDR, {r1[31:24], r2[23:16], r1[15:8], r2[7:0]},
       1'b0, 4'hF);
    wb(PFM_SEL_HIGH_ADDR, r1, 1'b1, 4'hF);
    wb(PFM_SEL_HIGH_ADDR, r1, 1'b0, 4'hF);
    for (int i = 0; i < 24; i++) begin
      periph_out <= pfm_periph_out_t'(23'($urandom));
      gpio_out <= $urandom;
      port_direction_bits <= $urandom;
      ext <= $urandom;
      // Pin is routed before the peripheral's activity is judged
      set_pin(tp[i], tc[i][1:0]);
      e = exp_pad(tp[i], tc[i][1:0]);
      check_val(32'({pad_oe[tp[i]], pad_oe[tp[i]] & pad_out[tp[i]]}),
        32'({e[1], e[1] & e[0]}));
    end
    ext <= 32'hFFFFFFFF;
    set_pin(1, 2'h1);
    check_val(32'(periph_in.uart0_receive), 32'h1);
    set_pin(14, 2'h1);
    check_val(32'(periph_in.external_irq_1), 32'h1);
    set_pin(15, 2'h3);
    check_val(32'(periph_in.uart1_ring_indicator), 32'h1);
    set_pin(11, 2'h2);
    check_val(32'(periph_in.timer1_capture_1), 32'h1);
    check_val(32'({periph_in.uart1_clear_to_send, periph_in.external_irq_1,
      periph_in.uart0_receive}), 32'h0);
    set_pin(10, 2'h3);
    check_val(32'({adc_reading_valid, pad_dig_en[11:10], gpio_in[10]}),
      32'({3'h1, 2'h2, 1'b0}));
    lv = $urandom & ~32'h00004000;
    do_reset(lv, 1'b1);
    repeat (2) @(posedge core_clk);
    check_val(32'({debug_mode, isp_request}), 32'h3);
    check_val(32'(debug_in), 32'({lv[27], lv[28], lv[29], lv[30]}));
    wb(PFM_SEL_LOW_ADDR, PFM_SEL_RESET, 1'b0, 4'hF);
    debug_data_out <= 1'b1;
    debug_data_out_oe <= 1'b1;
    // Test clock moves far slower than one sixth of the core clock
    ext[29] <= ~lv[29];
    repeat (8) @(posedge core_clk);
    check_val(32'({pad_oe[31], pad_out[31]}), 32'h3);
    check_val(32'(debug_in.test_clock), 32'(!lv[29]));
    final_report();
  end
endmodule : pfm_pin_mux_bench
